// ### verilog/bfcl_loader.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module bfcl_loader
  import bfcl_pkg::*;
#(
  parameter int NCFG = 4
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash preload
  input  wire logic        fl_wr_en,
  input  wire logic [4:0]  fl_wr_addr,
  input  wire logic [31:0] fl_wr_data,
  input  wire logic        fl_wr_bad,
  // System
  output logic             core_release,
  output logic             lower_panel2,
  output logic             irq
);
  typedef struct packed {
    bfcl_state_t  st;
    logic         panel;
    logic         alt;
    logic [2:0]   step;
    logic         t1_ok;
    logic [15:0]  t1;
    logic         t2_ok;
    logic [15:0]  t2;
    logic         low2;
    logic         err;
    logic         fail;
    logic [31:0]  sign;
    logic [31:0]  cp;
    logic [NCFG*32-1:0] cfg;
    logic [2:0]   irq_st;
    logic [2:0]   irq_mask;
    logic         release_o;
    logic         irq_o;
    logic [31:0]  rdata;
    logic         rdy;
    logic         serr;
  } bfcl_regs_t;

  bfcl_regs_t  r_ff;
  bfcl_regs_t  nxt_r;
  bfcl_frd_t   frd;
  bfcl_frsp_t  frsp;
  logic        wr_stb;
  logic        rd_stb;

  bfcl_apb u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb)
  );

  bfcl_flash u_flash (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (fl_wr_en),
    .wr_addr (fl_wr_addr),
    .wr_data (fl_wr_data),
    .wr_bad  (fl_wr_bad),
    .rd      (frd),
    .rsp     (frsp)
  );

  function automatic logic seq_ok(input logic [31:0] w);
    seq_ok = (w[31:16] == ~w[15:0]);
  endfunction

  // Alternates sit ALT_OFS words above their primaries
  function automatic logic [3:0] word_idx(input logic [2:0] s, input logic a);
    logic [3:0] b;
    b = (s == 3'd0) ? WI_SEQ : (s == 3'd1) ? WI_SIGN : (s == 3'd2) ? WI_CP
        : 4'(WI_CFG0 + 4'(s) - 4'd3);
    word_idx = a ? 4'(b + ALT_OFS) : b;
  endfunction

  function automatic logic [31:0] cfg_word(input bfcl_regs_t r, input int i);
    cfg_word = r.cfg[i*32 +: 32];
  endfunction

  // Flash request issued combinationally from state; response 1 cycle later
  always_comb begin
    frd.req   = (r_ff.st == ST_SEQ1) || (r_ff.st == ST_SEQ2) || (r_ff.st == ST_LOAD);
    frd.panel = r_ff.panel;
    frd.idx   = word_idx(r_ff.step, r_ff.alt);
  end

  // Reads decode the address seen in the setup cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:       rd_mux = {31'h0, r_ff.release_o};
      OFS_STATUS:     rd_mux = {25'h0, r_ff.st};
      OFS_RESET_STAT: rd_mux = (32'(r_ff.err) << RST_CFG_ERR_BIT)
                             | (32'(r_ff.fail) << RST_CFG_FAIL_BIT)
                             | {31'h0, r_ff.low2};
      OFS_IRQ_STAT:   rd_mux = {29'h0, r_ff.irq_st};
      OFS_IRQ_MASK:   rd_mux = {29'h0, r_ff.irq_mask};
      OFS_SIGN:       rd_mux = r_ff.sign;
      OFS_CP:         rd_mux = r_ff.cp;
      OFS_ALT_CFG3, OFS_ALT_CFG2, OFS_ALT_CFG1, OFS_ALT_CFG0:
                      rd_mux = 32'h0000_0000;
      default: begin
        for (int i = 0; i < NCFG; i++) begin
          if (paddr == 16'(OFS_CFG_BASE + 16'(i * 4))) begin
            rd_mux = cfg_word(r_ff, i);
          end
        end
      end
    endcase
  end

  // Alternate window decodes but reads zero: no copy of it is kept here
  logic addr_ok;
  always_comb begin
    addr_ok = (paddr <= OFS_CP) && (paddr[1:0] == 2'b00);
    addr_ok = addr_ok || (paddr >= OFS_CFG_BASE && paddr < 16'(OFS_CFG_BASE + 16'(NCFG * 4))
              && paddr[1:0] == 2'b00);
    addr_ok = addr_ok || paddr == OFS_ALT_CFG3 || paddr == OFS_ALT_CFG2
              || paddr == OFS_ALT_CFG1 || paddr == OFS_ALT_CFG0;
  end

  always_comb begin
    logic [2:0] ev;
    logic       use_alt;
    nxt_r = r_ff;
    ev    = 3'b000;
    use_alt = 1'b0;
    nxt_r.rdy  = psel & ~penable;
    nxt_r.serr = 1'b0;
    case (r_ff.st)
      ST_IDLE: begin
        // Panel one primary sequence word first
        nxt_r.st    = ST_SEQ1;
        nxt_r.panel = 1'b0;
        nxt_r.alt   = 1'b0;
        nxt_r.step  = 3'd0;
      end
      ST_SEQ1, ST_SEQ2: begin
        nxt_r.st = ST_WAIT;
      end
      ST_LOAD: begin
        nxt_r.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (frsp.valid) begin
          use_alt = frsp.ecc_fail || (r_ff.step == 3'd0 && !seq_ok(frsp.data));
          if (use_alt && !r_ff.alt) begin
            // A bad check field alone reroutes without flagging an ECC fault
            if (frsp.ecc_fail) begin
              nxt_r.err = 1'b1;
            end
            nxt_r.alt = 1'b1;
            nxt_r.st  = (r_ff.step == 3'd0) ? (r_ff.panel ? ST_SEQ2 : ST_SEQ1) : ST_LOAD;
          end else begin
            if (use_alt) begin
              nxt_r.fail = 1'b1;
            end
            nxt_r.alt = 1'b0;
            if (r_ff.step == 3'd0 && !r_ff.panel) begin
              nxt_r.t1    = frsp.data[15:0];
              nxt_r.t1_ok = !use_alt;
              nxt_r.panel = 1'b1;
              nxt_r.st    = ST_SEQ2;
            end else if (r_ff.step == 3'd0) begin
              nxt_r.t2    = frsp.data[15:0];
              nxt_r.t2_ok = !use_alt;
              nxt_r.st    = ST_PICK;
            end else begin
              case (r_ff.step)
                3'd1:    nxt_r.sign = use_alt ? DEF_SIGN : frsp.data;
                3'd2:    nxt_r.cp   = use_alt ? DEF_CP : frsp.data;
                default: nxt_r.cfg[(32'(r_ff.step) - 3) * 32 +: 32] =
                           use_alt ? DEF_CFG : frsp.data;
              endcase
              if (r_ff.step == 3'(NUM_LOAD - 1 + NCFG - 4 + 1) || r_ff.step == 3'd7) begin
                nxt_r.st = ST_DONE;
              end else begin
                nxt_r.step = 3'(r_ff.step + 3'd1);
                nxt_r.st   = ST_LOAD;
              end
            end
          end
        end
      end
      ST_PICK: begin
        // Unsigned compare; a failed tag loses to any good tag
        if (r_ff.t2_ok && (!r_ff.t1_ok || r_ff.t2 > r_ff.t1)) begin
          nxt_r.low2 = 1'b1;
        end else begin
          nxt_r.low2 = 1'b0;
        end
        nxt_r.panel = (r_ff.t2_ok && (!r_ff.t1_ok || r_ff.t2 > r_ff.t1));
        nxt_r.step  = 3'd1;
        nxt_r.alt   = 1'b0;
        nxt_r.st    = ST_LOAD;
      end
      ST_DONE: begin
        nxt_r.release_o = 1'b1;
        if (!r_ff.release_o) begin
          ev[IRQ_DONE_BIT] = 1'b1;
          ev[IRQ_ERR_BIT]  = r_ff.err;
          ev[IRQ_FAIL_BIT] = r_ff.fail;
        end
      end
      default: nxt_r.st = ST_IDLE;
    endcase

    // Captured in setup so the data stand through the access phase
    if (psel & ~penable) begin
      nxt_r.rdata = addr_ok ? rd_mux : 32'h0000_0000;
      nxt_r.serr  = ~addr_ok;
    end
    if (wr_stb) begin
      if (paddr == OFS_IRQ_STAT) begin
        nxt_r.irq_st = r_ff.irq_st & ~pwdata[2:0];
      end
      if (paddr == OFS_IRQ_MASK) begin
        nxt_r.irq_mask = pwdata[2:0];
      end
    end
    // Set beats clear in the same cycle
    nxt_r.irq_st = nxt_r.irq_st | ev;
    nxt_r.irq_o  = |(nxt_r.irq_st & nxt_r.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff    <= '0;
      r_ff.st <= ST_IDLE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign prdata       = r_ff.rdata;
  assign pready       = r_ff.rdy;
  assign pslverr      = r_ff.serr;
  assign core_release = r_ff.release_o;
  assign lower_panel2 = r_ff.low2;
  assign irq          = r_ff.irq_o;

  property p_pick(logic exp);
    @(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_PICK && r_ff.t1_ok && r_ff.t2_ok && (r_ff.t2 > r_ff.t1) == exp)
      |=> lower_panel2 == exp;
  endproperty
  swap_map_a:     assert property (p_pick(1'b1)) else $error("swap missing");
  keep_map_a:     assert property (p_pick(1'b0)) else $error("keep missing");
  load_panel_a:   assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_LOAD) |-> frd.panel == r_ff.low2)
    else $error("wrong panel");
  pick_step_a:    assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_PICK) |=> r_ff.st == ST_LOAD && r_ff.step == 3'd1 && !r_ff.alt)
    else $error("load does not start at sign word");
  step_range_a:   assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_LOAD) |-> r_ff.step >= 3'd1 && r_ff.step <= 3'(NUM_LOAD + NCFG - 4))
    else $error("load step out of range");
  seq_panel_a:    assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_SEQ1 || r_ff.st == ST_SEQ2) |-> frd.panel == (r_ff.st == ST_SEQ2))
    else $error("sequence word from wrong panel");
  err_flag_a:     assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_WAIT && frsp.valid && frsp.ecc_fail && !r_ff.alt)
      |=> r_ff.err && r_ff.alt)
    else $error("err flag");
  check_only_a:   assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_WAIT && frsp.valid && !frsp.ecc_fail && !r_ff.err) |=> !r_ff.err)
    else $error("err flag without ecc fault");
  err_hold_a:     assert property (@(posedge pclk) disable iff (!presetn)
    r_ff.err |=> r_ff.err)
    else $error("err flag dropped");
  fail_flag_a:    assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_WAIT && frsp.valid && frsp.ecc_fail && r_ff.alt) |=> r_ff.fail)
    else $error("fail flag");
  fail_hold_a:    assert property (@(posedge pclk) disable iff (!presetn)
    r_ff.fail |=> r_ff.fail)
    else $error("fail flag dropped");
  fail_sign_a:    assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_WAIT && frsp.valid && frsp.ecc_fail && r_ff.alt && r_ff.step == 3'd1)
      |=> r_ff.sign == DEF_SIGN)
    else $error("default sign not applied");
  fail_cp_a:      assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_WAIT && frsp.valid && frsp.ecc_fail && r_ff.alt && r_ff.step == 3'd2)
      |=> r_ff.cp == DEF_CP)
    else $error("default protect not applied");
  fail_cfg_a:     assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_WAIT && frsp.valid && frsp.ecc_fail && r_ff.alt && r_ff.step == 3'd3)
      |=> r_ff.cfg[31:0] == DEF_CFG)
    else $error("default config not applied");
  seq_check_a:    assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.st == ST_WAIT && frsp.valid && r_ff.step == 3'd0 && !r_ff.alt
     && frsp.data[31:16] != ~frsp.data[15:0]) |=> r_ff.alt)
    else $error("bad seq");
  alt_index_a:    assert property (@(posedge pclk) disable iff (!presetn)
    frd.req && r_ff.alt |-> frd.idx >= ALT_OFS)
    else $error("alt idx");
  release_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_release |-> r_ff.st == ST_DONE && !frd.req)
    else $error("early release");
  release_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_release |=> core_release)
    else $error("release dropped");
  irq_level_a:    assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(r_ff.irq_st & r_ff.irq_mask))
    else $error("irq level");
  ready_access_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_stb || rd_stb) |-> pready)
    else $error("access phase without ready");
  done_c:  cover property (@(posedge pclk) $rose(core_release));
  swap_c:  cover property (@(posedge pclk) $rose(lower_panel2));
  err_c:   cover property (@(posedge pclk) $rose(r_ff.err));
  fail_c:  cover property (@(posedge pclk) $rose(r_ff.fail));
  alt_seq_c: cover property (@(posedge pclk) r_ff.st == ST_SEQ2 && r_ff.alt);
endmodule
`default_nettype wire

// ### pkg/bfcl_pkg.sv
`default_nettype none
package bfcl_pkg;

  // APB register byte offsets
  localparam logic [15:0] OFS_CTRL       = 16'h0000;
  localparam logic [15:0] OFS_STATUS     = 16'h0004;
  localparam logic [15:0] OFS_RESET_STAT = 16'h0008;
  localparam logic [15:0] OFS_IRQ_STAT   = 16'h000C;
  localparam logic [15:0] OFS_IRQ_MASK   = 16'h0010;
  localparam logic [15:0] OFS_SIGN       = 16'h0014;
  localparam logic [15:0] OFS_CP         = 16'h0018;
  localparam logic [15:0] OFS_CFG_BASE   = 16'h0020;
  localparam logic [15:0] OFS_ALT_CFG3   = 16'hFF40;
  localparam logic [15:0] OFS_ALT_CFG2   = 16'hFF44;
  localparam logic [15:0] OFS_ALT_CFG1   = 16'hFF48;
  localparam logic [15:0] OFS_ALT_CFG0   = 16'hFF4C;

  // Flash word index within a panel's configuration space
  localparam logic [3:0] WI_SEQ      = 4'h0;
  localparam logic [3:0] WI_SIGN     = 4'h1;
  localparam logic [3:0] WI_CP       = 4'h2;
  localparam logic [3:0] WI_CFG0     = 4'h3;
  localparam int         NUM_LOAD    = 6;
  localparam logic [3:0] ALT_OFS     = 4'h8;

  // Reset-status bit positions
  localparam int RST_CFG_ERR_BIT  = 27;
  localparam int RST_CFG_FAIL_BIT = 26;

  // Interrupt status layout
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT  = 1;
  localparam int IRQ_FAIL_BIT = 2;

  // Defaults used when both copies fail
  localparam logic [31:0] DEF_SIGN = 32'h0000_0000;
  localparam logic [31:0] DEF_CP   = 32'hFFFF_FFFF;
  localparam logic [31:0] DEF_CFG  = 32'hFFFF_FFFF;

  // Flash read latency of the panel model
  localparam int FLASH_RD_NS   = 50;
  localparam int CLK_PERIOD_NS = 50;
  localparam int FLASH_RD_CYC  = (FLASH_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_SEQ1  = 7'b0000010,
    ST_SEQ2  = 7'b0000100,
    ST_PICK  = 7'b0001000,
    ST_LOAD  = 7'b0010000,
    ST_WAIT  = 7'b0100000,
    ST_DONE  = 7'b1000000
  } bfcl_state_t;

  typedef struct packed {
    logic        req;
    logic        panel;
    logic [3:0]  idx;
  } bfcl_frd_t;

  typedef struct packed {
    logic        valid;
    logic        ecc_fail;
    logic [31:0] data;
  } bfcl_frsp_t;

endpackage
`default_nettype wire

// ### verilog/bfcl_flash.sv
`timescale 1ns/1ps
`default_nettype none
// Both boot panels: primary words at idx, alternates at idx+ALT_OFS
module bfcl_flash
  import bfcl_pkg::*;
#(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Preload port
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_addr,
  input  wire logic [31:0] wr_data,
  input  wire logic       wr_bad,
  // Read port
  input  wire bfcl_frd_t  rd,
  output var bfcl_frsp_t  rsp
);
  logic [31:0] mem   [DEPTH];
  logic        bad   [DEPTH];
  bfcl_frsp_t  rsp_ff;

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
      bad[wr_addr] <= wr_bad;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid    <= rd.req;
      rsp_ff.ecc_fail <= bad[{rd.panel, rd.idx}];
      rsp_ff.data     <= mem[{rd.panel, rd.idx}];
    end
  end
  assign rsp = rsp_ff;
endmodule
`default_nettype wire

// ### verilog/bfcl_apb.sv
`timescale 1ns/1ps
`default_nettype none
// Zero-wait APB slave front end; register decode lives in the top
module bfcl_apb (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  output logic             wr_stb,
  output logic             rd_stb
);
  assign wr_stb = psel & penable & pwrite;
  assign rd_stb = psel & penable & ~pwrite;
endmodule
`default_nettype wire

// ### tb/bfcl_flash_image.sv
`timescale 1ns/1ps
`default_nettype none
// Boot panel image writer, drives the preload port while reset is low
module bfcl_flash_image (
  // Clock
  input  wire logic        pclk,
  // Preload
  output logic             fl_wr_en,
  output logic [4:0]       fl_wr_addr,
  output logic [31:0]      fl_wr_data,
  output logic             fl_wr_bad
);
  initial begin
    fl_wr_en   = 1'b0;
    fl_wr_addr = 5'h00;
    fl_wr_data = 32'h0000_0000;
    fl_wr_bad  = 1'b0;
  end

  function automatic logic [31:0] wv(input logic p, input logic [3:0] i);
    return {8'hA5, 7'h00, p, 12'h000, i};
  endfunction

  // Fault bits: 0 broken check on panel two primary, 1 primary sign bad, 2 alternate sign bad
  task automatic load(input logic [15:0] t1, t2, t2a, input logic [2:0] f);
    logic [15:0] tag;
    logic [4:0]  a;
    for (int k = 0; k < 32; k++) begin
      a = 5'(k);
      tag = a[4] ? (a[3] ? t2a : t2) : t1;
      @(posedge pclk);
      fl_wr_en   <= 1'b1;
      fl_wr_addr <= a;
      if (a[2:0] == 3'h0) begin
        fl_wr_data <= {~tag[15:1], ~tag[0] ^ (f[0] & a[4] & ~a[3]), tag};
      end else begin
        fl_wr_data <= wv(a[4], {1'b0, a[2:0]}) ^ (a[3] ? 32'h00FF_0000 : 32'h0);
      end
      fl_wr_bad  <= (a[2:0] == 3'h1) & (a[3] ? f[2] : f[1]);
    end
    // Whole image goes in as one block preload, never patched word by word
    @(posedge pclk);
    fl_wr_en <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bfcl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        fl_wr_en, fl_wr_bad, core_release, lower_panel2, irq;
  logic [4:0]  fl_wr_addr;
  logic [31:0] fl_wr_data;
  int          error_cnt, tests_run;

  bfcl_flash_image img (.pclk(pclk), .fl_wr_en(fl_wr_en), .fl_wr_addr(fl_wr_addr),
    .fl_wr_data(fl_wr_data), .fl_wr_bad(fl_wr_bad));

  bfcl_loader DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fl_wr_en(fl_wr_en), .fl_wr_addr(fl_wr_addr),
    .fl_wr_data(fl_wr_data), .fl_wr_bad(fl_wr_bad), .core_release(core_release),
    .lower_panel2(lower_panel2), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic run(input logic [15:0] t1, t2, t2a, input logic [2:0] f);
    int n;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    img.load(t1, t2, t2a, f);
    @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (core_release !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n == 500) begin
      error_cnt++;
      close_out();
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0000_0000;
    error_cnt = 0;
    tests_run = 0;
    // Equal tags keep panel one low
    run(16'h0005, 16'h0005, 16'h0005, 3'h0);
    chk(32'(lower_panel2), 32'h0);
    apb(1'b0, OFS_SIGN, 32'h0);
    chk(rd, img.wv(1'b0, WI_SIGN));
    // Top bit set shows the compare is unsigned
    run(16'h0001, 16'h8000, 16'h8000, 3'h0);
    chk(32'(lower_panel2), 32'h1);
    apb(1'b0, OFS_CFG_BASE, 32'h0);
    chk(rd, img.wv(1'b1, WI_CFG0));
    apb(1'b0, OFS_RESET_STAT, 32'h0);
    chk(rd, 32'h0000_0001);
    // Broken check on the higher primary tag falls back to a lower alternate
    run(16'h0003, 16'h0009, 16'h0001, 3'h1);
    chk(32'(lower_panel2), 32'h0);
    apb(1'b0, OFS_RESET_STAT, 32'h0);
    chk(rd, 32'h0000_0000);
    // Primary sign word unreadable
    run(16'h0002, 16'h0001, 16'h0001, 3'h2);
    apb(1'b0, OFS_RESET_STAT, 32'h0);
    chk(rd, 32'h1 << RST_CFG_ERR_BIT);
    apb(1'b0, OFS_SIGN, 32'h0);
    chk(rd, img.wv(1'b0, WI_SIGN) ^ 32'h00FF_0000);
    chk(32'(irq), 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0000_0003);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0000_0001);
    // Both copies of the sign word unreadable
    run(16'h0002, 16'h0001, 16'h0001, 3'h6);
    apb(1'b0, OFS_RESET_STAT, 32'h0);
    chk(32'(rd[RST_CFG_FAIL_BIT]), 32'h1);
    apb(1'b1, OFS_SIGN, 32'h1234_5678);
    apb(1'b0, OFS_SIGN, 32'h0);
    chk(rd, DEF_SIGN);
    // Unmapped address refused, alternate window reads zero
    apb(1'b0, 16'h0100, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, OFS_ALT_CFG3 + 16'(4 * k), 32'h0);
      chk({rd[30:0], err}, 32'h0);
    end
    close_out();
  end
endmodule
`default_nettype wire
